// ### rtl/sstf_map.svh
`ifndef SSTF_MAP_SVH
`define SSTF_MAP_SVH
// clock and MFM half-cell timing
`define SSTF_CLK_NS      50
`define SSTF_HC_NS       100
`define SSTF_HC_CLKS     ((`SSTF_HC_NS + `SSTF_CLK_NS - 1) / `SSTF_CLK_NS)
`define SSTF_CELLS       16
// address mark bytes and the A1 pattern with its clock bit omitted
`define SSTF_AM_LEAD     8'hA1
`define SSTF_AM_ID       8'hFE
`define SSTF_AM_DATA     8'hF8
`define SSTF_MARK_CELLS  16'h4489
`define SSTF_MISS_MASK   16'h0020
// crc-16, x^16 + x^12 + x^5 + 1
`define SSTF_CRC_POLY    16'h1021
`define SSTF_CRC_INIT    16'hFFFF
// track layout
`define SSTF_NSEC        32
`define SSTF_SEC_BYTES   256
`define SSTF_INTERLEAVE  4
`define SSTF_GAP1_LEN    16
`define SSTF_GAP1_MIN    12
`define SSTF_GAP2_LEN    16
`define SSTF_GAP3_LEN    16
`define SSTF_GAP3_MIN    8
`define SSTF_SYNC_LEN    12
`define SSTF_SYNC_BYTE   8'h00
`define SSTF_FILL_BYTE   8'h4E
`define SSTF_AM_LEN      2
`define SSTF_ID_LEN      3
`define SSTF_CRC_LEN     2
// head byte flag positions
`define SSTF_HB_BAD      7
`define SSTF_HB_CYL9     6
`define SSTF_HB_CYL8     5
`define SSTF_FIFO_DEPTH  8
`endif

// ### rtl/sstf_pkg.sv
`default_nettype none
package sstf_pkg;
  // one sector identity as written into or read from an ID field
  typedef struct packed {
    logic [9:0] cyl;
    logic [3:0] head;
    logic [7:0] sector;
    logic       bad;
  } sstf_id_s;

  typedef enum logic [3:0] {
    F_IDLE, F_WAIT_IDX, F_GAP1, F_SYNC_ID, F_AM_ID, F_ID, F_CRC_ID,
    F_GAP2, F_SYNC_DAT, F_AM_DAT, F_DATA, F_CRC_DAT, F_GAP3, F_GAP4
  } sstf_fmt_e;

  typedef enum logic [2:0] {
    R_HUNT, R_AM, R_ID, R_IDCRC, R_DATA, R_DCRC
  } sstf_rd_e;
endpackage : sstf_pkg
`default_nettype wire

// ### rtl/sstf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sstf_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wp_r[AW] != rp_r[AW]) &&
                       (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = (wp_r != rp_r);
  assign out_data  = mem_r[rp_r[AW-1:0]];

  // storage write
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_r <= wp_r + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule : sstf_fifo
`default_nettype wire

// ### rtl/sstf_crc16.sv
`timescale 1ns/1ps
`default_nettype none
`include "sstf_map.svh"
module sstf_crc16 (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic [15:0]      crc
);
  logic [15:0] crc_r;
  logic [15:0] stage [9];

  // preset first when a mark starts the field
  assign stage[0] = init ? `SSTF_CRC_INIT : crc_r;
  assign crc      = crc_r;

  // one shift stage per data bit, msb first
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      logic fb;
      assign fb = stage[i][15] ^ data[7-i];
      assign stage[i+1] = {stage[i][14:0], 1'b0} ^
                          (fb ? `SSTF_CRC_POLY : 16'h0000);
    end
  endgenerate

  // register update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_r <= `SSTF_CRC_INIT;
    end else if (en) begin
      crc_r <= stage[8];
    end else if (init) begin
      crc_r <= `SSTF_CRC_INIT;
    end
  end
endmodule : sstf_crc16
`default_nettype wire

// ### rtl/sstf_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "sstf_map.svh"
module sstf_ctrl #(
  parameter int         NSEC      = `SSTF_NSEC,
  parameter int         SEC_BYTES = `SSTF_SEC_BYTES,
  parameter int         IL        = `SSTF_INTERLEAVE,
  parameter int         GAP1_LEN  = `SSTF_GAP1_LEN,
  parameter int         GAP2_LEN  = `SSTF_GAP2_LEN,
  parameter int         GAP3_LEN  = `SSTF_GAP3_LEN,
  parameter int         SYNC_LEN  = `SSTF_SYNC_LEN,
  parameter logic [7:0] SYNC_BYTE = `SSTF_SYNC_BYTE,
  parameter logic [7:0] FILL_BYTE = `SSTF_FILL_BYTE,
  parameter int         FIFO_D    = `SSTF_FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              index_n,
  output logic                   wr_gate,
  output logic                   wr_data,
  input  wire logic              rd_data,
  input  wire logic              fmt_start,
  input  wire sstf_pkg::sstf_id_s fmt_id,
  input  wire logic [NSEC-1:0]   fmt_bad_mask,
  input  wire logic              fmt_valid,
  output logic                   fmt_ready,
  input  wire logic [7:0]        fmt_byte,
  output logic                   fmt_busy,
  output logic                   fmt_done,
  output logic                   fmt_overrun,
  output logic                   fmt_underrun,
  input  wire logic              rd_en,
  output sstf_pkg::sstf_id_s     id_out,
  output logic                   id_valid,
  output logic                   id_bad,
  output logic                   id_crc_err,
  output logic [7:0]             dat_byte,
  output logic                   dat_valid,
  output logic                   dat_ok,
  output logic                   dat_crc_err
);
  localparam int HC = `SSTF_HC_CLKS;
  localparam int SW = (NSEC > 1) ? $clog2(NSEC) : 1;
  localparam int G1 = (GAP1_LEN < `SSTF_GAP1_MIN) ? `SSTF_GAP1_MIN
                                                  : GAP1_LEN;
  localparam int G3 = (GAP3_LEN < `SSTF_GAP3_MIN) ? `SSTF_GAP3_MIN
                                                  : GAP3_LEN;

  // ---- pin synchronisers: change counts when stages two and three agree
  logic [2:0] idx_s_r;
  logic [2:0] rds_s_r;
  logic       idx_lvl_r;
  logic       idx_lvl_d_r;
  logic       rd_lvl_r;
  logic       rd_lvl_d_r;
  logic       idx_fall;
  logic       rd_pulse;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_s_r     <= 3'h7;
      rds_s_r     <= 3'h0;
      idx_lvl_r   <= 1'b1;
      idx_lvl_d_r <= 1'b1;
      rd_lvl_r    <= 1'b0;
      rd_lvl_d_r  <= 1'b0;
    end else begin
      idx_s_r     <= {idx_s_r[1:0], index_n};
      rds_s_r     <= {rds_s_r[1:0], rd_data};
      if (idx_s_r[1] == idx_s_r[2]) begin
        idx_lvl_r <= idx_s_r[2];
      end
      if (rds_s_r[1] == rds_s_r[2]) begin
        rd_lvl_r <= rds_s_r[2];
      end
      idx_lvl_d_r <= idx_lvl_r;
      rd_lvl_d_r  <= rd_lvl_r;
    end
  end

  assign idx_fall = idx_lvl_d_r & ~idx_lvl_r;
  assign rd_pulse = ~rd_lvl_d_r & rd_lvl_r;

  // ---- MFM encoder for one byte, clock bit is nor of neighbours
  function automatic logic [15:0] mfm_enc(input logic [7:0] b,
                                          input logic p);
    logic [15:0] w;
    logic        q;
    w = 16'h0000;
    q = p;
    for (int k = 7; k >= 0; k--) begin
      w[2*k+1] = ~(q | b[k]);
      w[2*k]   = b[k];
      q        = b[k];
    end
    return w;
  endfunction : mfm_enc

  // ---- write side state
  sstf_pkg::sstf_fmt_e f_st_r;
  sstf_pkg::sstf_id_s  req_r;
  logic [15:0]         f_cnt_r;
  logic [5:0]          f_sec_r;
  logic [7:0]          cur_byte;
  logic                is_mark;
  logic                f_active;
  logic [15:0]         f_len;
  logic                hc_en;
  logic [3:0]          hc_cnt_r;
  logic [3:0]          cell_r;
  logic [15:0]         wsh_r;
  logic                prev_r;
  logic                bnd;
  logic [7:0]          sec_num;
  logic [15:0]         wcrc;
  logic                fifo_v;
  logic [7:0]          fifo_d;
  logic                fifo_pop;
  logic                wcrc_en;

  assign f_active = (f_st_r != sstf_pkg::F_IDLE) &&
                    (f_st_r != sstf_pkg::F_WAIT_IDX);
  assign hc_en    = (hc_cnt_r == 4'(HC - 1));
  assign bnd      = f_active && hc_en && (cell_r == 4'hF);
  assign fmt_busy = (f_st_r != sstf_pkg::F_IDLE);

  // interleave mapping from physical slot to sector number
  assign sec_num = 8'((f_sec_r % IL) * (NSEC / IL) + f_sec_r / IL);

  // byte due in the current slot
  always_comb begin
    cur_byte = 8'h00;
    is_mark  = 1'b0;
    case (f_st_r)
      sstf_pkg::F_GAP1, sstf_pkg::F_GAP2,
      sstf_pkg::F_GAP3, sstf_pkg::F_GAP4: cur_byte = FILL_BYTE;
      sstf_pkg::F_SYNC_ID, sstf_pkg::F_SYNC_DAT: cur_byte = SYNC_BYTE;
      sstf_pkg::F_AM_ID, sstf_pkg::F_AM_DAT: begin
        is_mark  = (f_cnt_r == 16'h0000);
        cur_byte = is_mark ? `SSTF_AM_LEAD :
                   (f_st_r == sstf_pkg::F_AM_ID) ? `SSTF_AM_ID
                                                 : `SSTF_AM_DATA;
      end
      sstf_pkg::F_ID: begin
        case (f_cnt_r[1:0])
          2'h0: cur_byte = req_r.cyl[7:0];
          2'h1: begin
            cur_byte = {1'b0, 1'b0, 1'b0, 1'b0, req_r.head};
            cur_byte[`SSTF_HB_BAD]  = fmt_bad_mask[sec_num[SW-1:0]];
            cur_byte[`SSTF_HB_CYL9] = req_r.cyl[9];
            cur_byte[`SSTF_HB_CYL8] = req_r.cyl[8];
          end
          default: cur_byte = sec_num;
        endcase
      end
      sstf_pkg::F_DATA: cur_byte = fifo_v ? fifo_d : 8'h00;
      sstf_pkg::F_CRC_ID, sstf_pkg::F_CRC_DAT:
        cur_byte = (f_cnt_r == 16'h0000) ? wcrc[15:8] : wcrc[7:0];
      default: cur_byte = 8'h00;
    endcase
  end

  // length of each field in bytes
  always_comb begin
    case (f_st_r)
      sstf_pkg::F_GAP1: f_len = 16'(G1);
      sstf_pkg::F_SYNC_ID, sstf_pkg::F_SYNC_DAT: f_len = 16'(SYNC_LEN);
      sstf_pkg::F_AM_ID, sstf_pkg::F_AM_DAT: f_len = 16'(`SSTF_AM_LEN);
      sstf_pkg::F_ID: f_len = 16'(`SSTF_ID_LEN);
      sstf_pkg::F_CRC_ID, sstf_pkg::F_CRC_DAT: f_len = 16'(`SSTF_CRC_LEN);
      sstf_pkg::F_GAP2: f_len = 16'(GAP2_LEN);
      sstf_pkg::F_DATA: f_len = 16'(SEC_BYTES);
      sstf_pkg::F_GAP3: f_len = 16'(G3);
      default: f_len = 16'hFFFF;
    endcase
  end

  assign fifo_pop = bnd && (f_st_r == sstf_pkg::F_DATA);
  assign wcrc_en  = bnd && ((f_st_r == sstf_pkg::F_AM_ID) ||
                    (f_st_r == sstf_pkg::F_AM_DAT) ||
                    (f_st_r == sstf_pkg::F_ID) ||
                    (f_st_r == sstf_pkg::F_DATA));

  // data field bytes queue here until their slot comes round
  sstf_fifo #(
    .W (8),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fmt_valid),
    .in_ready  (fmt_ready),
    .in_data   (fmt_byte),
    .out_valid (fifo_v),
    .out_ready (fifo_pop),
    .out_data  (fifo_d)
  );

  // crc over mark, ID and data bytes, preset at each A1
  sstf_crc16 u_wcrc (
    .clk   (clk),
    .rst_n (rst_n),
    .init  (bnd && is_mark),
    .en    (wcrc_en),
    .data  (cur_byte),
    .crc   (wcrc)
  );

  // format sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      f_st_r       <= sstf_pkg::F_IDLE;
      f_cnt_r      <= 16'h0000;
      f_sec_r      <= 6'h00;
      req_r        <= '0;
      fmt_done     <= 1'b0;
      fmt_overrun  <= 1'b0;
      fmt_underrun <= 1'b0;
    end else begin
      fmt_done     <= 1'b0;
      fmt_overrun  <= 1'b0;
      fmt_underrun <= fifo_pop && !fifo_v;
      if (f_st_r == sstf_pkg::F_IDLE) begin
        if (fmt_start) begin
          f_st_r <= sstf_pkg::F_WAIT_IDX;
          req_r  <= fmt_id;
        end
      end else if (f_st_r == sstf_pkg::F_WAIT_IDX) begin
        if (idx_fall) begin
          f_st_r  <= sstf_pkg::F_GAP1;
          f_cnt_r <= 16'h0000;
          f_sec_r <= 6'h00;
        end
      end else if (idx_fall) begin
        f_st_r      <= sstf_pkg::F_IDLE;
        fmt_done    <= (f_st_r == sstf_pkg::F_GAP4);
        fmt_overrun <= (f_st_r != sstf_pkg::F_GAP4);
      end else if (bnd && (f_cnt_r != f_len - 16'h0001)) begin
        f_cnt_r <= f_cnt_r + 16'h0001;
      end else if (bnd) begin
        f_cnt_r <= 16'h0000;
        case (f_st_r)
          sstf_pkg::F_GAP1:     f_st_r <= sstf_pkg::F_SYNC_ID;
          sstf_pkg::F_SYNC_ID:  f_st_r <= sstf_pkg::F_AM_ID;
          sstf_pkg::F_AM_ID:    f_st_r <= sstf_pkg::F_ID;
          sstf_pkg::F_ID:       f_st_r <= sstf_pkg::F_CRC_ID;
          sstf_pkg::F_CRC_ID:   f_st_r <= sstf_pkg::F_GAP2;
          sstf_pkg::F_GAP2:     f_st_r <= sstf_pkg::F_SYNC_DAT;
          sstf_pkg::F_SYNC_DAT: f_st_r <= sstf_pkg::F_AM_DAT;
          sstf_pkg::F_AM_DAT:   f_st_r <= sstf_pkg::F_DATA;
          sstf_pkg::F_DATA:     f_st_r <= sstf_pkg::F_CRC_DAT;
          sstf_pkg::F_CRC_DAT:  f_st_r <= sstf_pkg::F_GAP3;
          sstf_pkg::F_GAP3: begin
            if (f_sec_r == 6'(NSEC - 1)) begin
              f_st_r <= sstf_pkg::F_GAP4;
            end else begin
              f_st_r  <= sstf_pkg::F_SYNC_ID;
              f_sec_r <= f_sec_r + 6'h01;
            end
          end
          default: f_st_r <= f_st_r;
        endcase
      end
    end
  end

  // half-cell divider, restarted at index so bytes line up with it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hc_cnt_r <= 4'h0;
      cell_r   <= 4'hF;
    end else if (f_st_r == sstf_pkg::F_WAIT_IDX) begin
      hc_cnt_r <= 4'h0;
      cell_r   <= 4'hF;
    end else if (hc_en) begin
      hc_cnt_r <= 4'h0;
      cell_r   <= cell_r + 4'h1;
    end else begin
      hc_cnt_r <= hc_cnt_r + 4'h1;
    end
  end

  // cell shifter: one MFM cell out per half-cell
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wsh_r   <= 16'h0000;
      prev_r  <= 1'b0;
      wr_data <= 1'b0;
      wr_gate <= 1'b0;
    end else if (!f_active || idx_fall) begin
      wsh_r   <= 16'h0000;
      prev_r  <= 1'b0;
      wr_data <= 1'b0;
      wr_gate <= 1'b0;
    end else if (hc_en) begin
      wr_gate <= 1'b1;
      wr_data <= wsh_r[15];
      if (bnd) begin
        wsh_r  <= mfm_enc(cur_byte, prev_r) &
                  ~(is_mark ? `SSTF_MISS_MASK : 16'h0000);
        prev_r <= cur_byte[0];
      end else begin
        wsh_r <= {wsh_r[14:0], 1'b0};
      end
    end
  end

  // ---- read side: cell recovery re-phased on every flux pulse
  sstf_pkg::sstf_rd_e r_st_r;
  logic [3:0]          rdiv_r;
  logic                rone_r;
  logic                rtick;
  logic [15:0]         rsh_r;
  logic [15:0]         rsh_nxt;
  logic [3:0]          rbit_r;
  logic [8:0]          rcnt_r;
  logic [7:0]          rbyte;
  logic                rbyte_ev;
  logic                rmark;
  logic [15:0]         rcrc;
  logic                id_ok_r;
  logic                chk_id_r;
  logic                chk_dat_r;
  sstf_pkg::sstf_id_s  id_hold_r;

  assign rtick    = (rdiv_r == 4'(HC - 1));
  assign rsh_nxt  = {rsh_r[14:0], rone_r | rd_pulse};
  assign rmark    = rtick && rd_en && (r_st_r == sstf_pkg::R_HUNT) &&
                    (rsh_nxt == `SSTF_MARK_CELLS);
  assign rbyte_ev = rtick && (rbit_r == 4'hF) &&
                    (r_st_r != sstf_pkg::R_HUNT);

  // data bits sit in the even cell positions
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dec
      assign rbyte[gi] = rsh_nxt[2*gi];
    end
  endgenerate

  // half-cell timing and cell shift register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdiv_r <= 4'h0;
      rone_r <= 1'b0;
      rsh_r  <= 16'h0000;
    end else if (rtick) begin
      rdiv_r <= 4'h0;
      rone_r <= 1'b0;
      rsh_r  <= rsh_nxt;
    end else if (rd_pulse) begin
      rdiv_r <= 4'h0;
      rone_r <= 1'b1;
    end else begin
      rdiv_r <= rdiv_r + 4'h1;
    end
  end

  sstf_crc16 u_rcrc (
    .clk   (clk),
    .rst_n (rst_n),
    .init  (rmark),
    .en    (rmark || rbyte_ev),
    .data  (rmark ? `SSTF_AM_LEAD : rbyte),
    .crc   (rcrc)
  );

  // field parser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_st_r    <= sstf_pkg::R_HUNT;
      rbit_r    <= 4'h0;
      rcnt_r    <= 9'h000;
      id_hold_r <= '0;
      chk_id_r  <= 1'b0;
      chk_dat_r <= 1'b0;
      dat_byte  <= 8'h00;
      dat_valid <= 1'b0;
    end else begin
      chk_id_r  <= 1'b0;
      chk_dat_r <= 1'b0;
      dat_valid <= 1'b0;
      if (rtick) begin
        rbit_r <= rbit_r + 4'h1;
      end
      if (!rd_en) begin
        r_st_r <= sstf_pkg::R_HUNT;
      end else if (rmark) begin
        r_st_r <= sstf_pkg::R_AM;
        rbit_r <= 4'h0;
        rcnt_r <= 9'h000;
      end else if (rbyte_ev) begin
        rcnt_r <= rcnt_r + 9'h001;
        case (r_st_r)
          sstf_pkg::R_AM: begin
            rcnt_r <= 9'h000;
            if (rbyte == `SSTF_AM_ID) begin
              r_st_r <= sstf_pkg::R_ID;
            end else if (rbyte == `SSTF_AM_DATA && id_ok_r) begin
              r_st_r <= sstf_pkg::R_DATA;
            end else begin
              r_st_r <= sstf_pkg::R_HUNT;
            end
          end
          sstf_pkg::R_ID: begin
            if (rcnt_r == 9'h000) begin
              id_hold_r.cyl[7:0] <= rbyte;
            end else if (rcnt_r == 9'h001) begin
              id_hold_r.head   <= rbyte[3:0];
              id_hold_r.cyl[9] <= rbyte[`SSTF_HB_CYL9];
              id_hold_r.cyl[8] <= rbyte[`SSTF_HB_CYL8];
              id_hold_r.bad    <= rbyte[`SSTF_HB_BAD];
            end else begin
              id_hold_r.sector <= rbyte;
              r_st_r <= sstf_pkg::R_IDCRC;
              rcnt_r <= 9'h000;
            end
          end
          sstf_pkg::R_DATA: begin
            dat_byte  <= rbyte;
            dat_valid <= 1'b1;
            if (rcnt_r == 9'(SEC_BYTES - 1)) begin
              r_st_r <= sstf_pkg::R_DCRC;
              rcnt_r <= 9'h000;
            end
          end
          sstf_pkg::R_IDCRC, sstf_pkg::R_DCRC: begin
            if (rcnt_r == 9'h001) begin
              r_st_r    <= sstf_pkg::R_HUNT;
              chk_id_r  <= (r_st_r == sstf_pkg::R_IDCRC);
              chk_dat_r <= (r_st_r == sstf_pkg::R_DCRC);
            end
          end
          default: r_st_r <= sstf_pkg::R_HUNT;
        endcase
      end
    end
  end

  // crc verdicts, two cycles after the last crc byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      id_ok_r     <= 1'b0;
      id_out      <= '0;
      id_valid    <= 1'b0;
      id_bad      <= 1'b0;
      id_crc_err  <= 1'b0;
      dat_ok      <= 1'b0;
      dat_crc_err <= 1'b0;
    end else begin
      id_valid    <= chk_id_r && (rcrc == 16'h0000);
      id_bad      <= chk_id_r && (rcrc == 16'h0000) && id_hold_r.bad;
      id_crc_err  <= chk_id_r && (rcrc != 16'h0000);
      dat_ok      <= chk_dat_r && (rcrc == 16'h0000);
      dat_crc_err <= chk_dat_r && (rcrc != 16'h0000);
      if (chk_id_r) begin
        id_ok_r <= (rcrc == 16'h0000) && !id_hold_r.bad;
        id_out  <= id_hold_r;
      end else if (chk_dat_r || !rd_en) begin
        id_ok_r <= 1'b0;
      end
    end
  end
endmodule : sstf_ctrl
`default_nettype wire

// ### dv/sstf_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module sstf_ctrl_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic index_n,
  input wire logic fmt_start,
  input wire logic fmt_busy,
  input wire logic fmt_done,
  input wire logic wr_gate,
  input wire logic wr_data,
  input wire logic id_valid,
  input wire logic id_bad,
  input wire logic id_crc_err,
  input wire logic dat_valid,
  input wire logic dat_ok,
  input wire logic dat_crc_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] age_r;
  logic       idx_r;
  // cycles since the last index fall, saturating at F
  always_ff @(posedge clk) begin
    idx_r <= index_n;
    if (!rst_n) age_r <= 4'hF;
    else if (idx_r && !index_n) age_r <= 4'h0;
    else if (age_r != 4'hF) age_r <= age_r + 4'h1;
  end
  a_gate_in_busy: assert property (wr_gate |-> fmt_busy)
    else $error("write gate outside a format");
  a_start_to_busy: assert property (
    fmt_start && !fmt_busy |=> fmt_busy)
    else $error("start not taken");
  a_gate_at_index: assert property (
    $rose(wr_gate) |-> age_r != 4'hF)
    else $error("gate rose away from index fall");
  a_done_ends_gate: assert property (
    fmt_done |=> !wr_gate && !fmt_done)
    else $error("gate or done held after done");
  a_cell_two_clk: assert property (
    $rose(wr_data) && wr_gate
    |=> (wr_data || !wr_gate) ##1 !wr_data)
    else $error("cell width or adjacent ones");
  a_id_verdict: assert property (id_valid |-> !id_crc_err)
    else $error("id good and crc error together");
  a_dat_verdict: assert property (dat_ok |-> !dat_crc_err)
    else $error("data good and crc error together");
  a_dat_spacing: assert property (dat_valid |=> !dat_valid [*8])
    else $error("data bytes too close");
  c_id: cover property (id_valid);
  c_bad: cover property (id_bad);
  c_dat_ok: cover property (dat_ok);
endmodule : sstf_ctrl_props
bind sstf_ctrl sstf_ctrl_props u_props (.clk(clk), .rst_n(rst_n),
  .index_n(index_n), .fmt_start(fmt_start), .fmt_busy(fmt_busy),
  .fmt_done(fmt_done), .wr_gate(wr_gate), .wr_data(wr_data),
  .id_valid(id_valid), .id_bad(id_bad), .id_crc_err(id_crc_err),
  .dat_valid(dat_valid), .dat_ok(dat_ok), .dat_crc_err(dat_crc_err));
`default_nettype wire

// ### dv/sstf_disk_model.sv
`timescale 1ns/1ps
`default_nettype none
module sstf_disk_model #(
  parameter int PER = 21000
) (
  input  wire logic clk,
  input  wire logic wr_gate,
  input  wire logic wr_data,
  output var logic  index_n,
  output var logic  rd_data
);
  int cnt = 0;
  // one index pulse a revolution, high when idle
  always @(posedge clk) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    index_n <= cnt < PER - 20;
  end
  // replays written flux; unwritten surface toggles, never a mark
  always @(posedge clk) begin
    rd_data <= wr_gate ? wr_data : ~rd_data;
  end
  initial begin
    index_n = 1'b1;
    rd_data = 1'b0;
  end
endmodule : sstf_disk_model
`default_nettype wire

// ### dv/sstf_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sstf_ctrl_tb;
  localparam int NS = 8;
  localparam int SB = 8;
  logic clk, rst_n, index_n, wr_gate, wr_data, rd_data, fmt_start;
  logic fmt_valid, fmt_ready, fmt_busy, fmt_done, fmt_overrun;
  logic fmt_underrun, rd_en, id_valid, id_bad, id_crc_err;
  logic dat_valid, dat_ok, dat_crc_err, feed;
  logic [7:0] fmt_byte, dat_byte;
  logic [NS-1:0] mask;
  logic [31:0] lf = 32'h46E23066;
  logic [7:0] sent[$];
  sstf_pkg::sstf_id_s fmt_id, id_out;
  int err_total, checked, slot, dptr, n_ok, n_done, n_und, n_ovr;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic int exp_sec(input int p);
    return (p % 4) * (NS / 4) + p / 4;
  endfunction : exp_sec
  sstf_ctrl #(.NSEC(NS), .SEC_BYTES(SB)) uut (.clk(clk), .rst_n(rst_n),
    .index_n(index_n), .wr_gate(wr_gate), .wr_data(wr_data),
    .rd_data(rd_data), .fmt_start(fmt_start), .fmt_id(fmt_id),
    .fmt_bad_mask(mask), .fmt_valid(fmt_valid), .fmt_ready(fmt_ready),
    .fmt_byte(fmt_byte), .fmt_busy(fmt_busy), .fmt_done(fmt_done),
    .fmt_overrun(fmt_overrun), .fmt_underrun(fmt_underrun),
    .rd_en(rd_en), .id_out(id_out), .id_valid(id_valid), .id_bad(id_bad),
    .id_crc_err(id_crc_err), .dat_byte(dat_byte), .dat_valid(dat_valid),
    .dat_ok(dat_ok), .dat_crc_err(dat_crc_err));
  sstf_disk_model u_disk (.clk(clk), .wr_gate(wr_gate),
    .wr_data(wr_data), .index_n(index_n), .rd_data(rd_data));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // random byte stream into the buffer, held until taken
  always @(posedge clk) begin
    lf <= lfsr(lf);
    if (fmt_valid && fmt_ready) sent.push_back(fmt_byte);
    if (!fmt_valid || fmt_ready) begin
      fmt_valid <= feed && lf[0] && sent.size() < NS * SB;
      fmt_byte <= lf[15:8];
    end
  end
  // read side watched on the loopback of the written track
  always @(negedge clk) if (rst_n) begin
    if (id_valid || id_bad) begin
      chk("id_bad", mask[exp_sec(slot)], id_bad);
      dptr = slot * SB;
      slot++;
    end
    if (id_valid) begin
      chk("sector", exp_sec(slot - 1), id_out.sector);
      chk("cyl", fmt_id.cyl, id_out.cyl);
      chk("head", fmt_id.head, id_out.head);
    end
    if (dat_valid) begin
      chk("dat", feed ? sent[dptr] : 8'h00, dat_byte);
      dptr++;
    end
    if (id_crc_err || dat_crc_err) chk("crc_err", 0, 1);
    n_ok += dat_ok;
    n_done += fmt_done;
    n_und += fmt_underrun;
    n_ovr += fmt_overrun;
  end
  // one whole-track format, fed or starved, with a start held while busy
  task automatic run(input logic fd);
    int t;
    sent = {};
    slot = 0;
    n_ok = 0;
    n_done = 0;
    n_und = 0;
    n_ovr = 0;
    feed <= fd;
    rd_en <= 1'b1;
    mask <= lf[NS-1:0] | 8'h01;
    fmt_id <= '{cyl: lf[25:16] | 10'h200, head: lf[3:0],
                sector: 8'h00, bad: 1'b0};
    fmt_start <= 1'b1;
    repeat (2) @(posedge clk);
    fmt_start <= 1'b0;
    t = 0;
    while (n_done == 0 && t < 50000) begin
      @(posedge clk);
      t++;
    end
    repeat (40) @(posedge clk);
    chk("ids", NS, slot);
    chk("dat_ok", NS - $countones(mask), n_ok);
    chk("done", 1, n_done);
    chk("overrun", 0, n_ovr);
    chk("underrun", !fd, n_und != 0);
  endtask : run
  initial begin
    rst_n = 1'b0;
    fmt_start = 1'b0;
    fmt_valid = 1'b0;
    fmt_byte = 8'h00;
    rd_en = 1'b0;
    feed = 1'b0;
    mask = '0;
    fmt_id = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    run(1'b1);
    run(1'b0);
    report_and_stop();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule : sstf_ctrl_tb
`default_nettype wire
